// [ocal_defines.svh]
// Timing counts and reset values for the offset-cancel sequencer
`ifndef OCAL_DEFINES_SVH
`define OCAL_DEFINES_SVH
`define OCAL_SIM_CYCLES      5'h10
`define OCAL_CNT_W           5
`define OCAL_NUM_CH          4
`define OCAL_CH_W            2
`define OCAL_BUSY_RST        1'h0
`endif

// [ocal_pkg.sv]
// Types shared by the offset-cancel sequencer files
package ocal_pkg;
  typedef enum logic [4:0] {
    ST_IDLE0 = 5'b0_0001,
    ST_CAL   = 5'b0_0010,
    ST_READY = 5'b0_0100,
    ST_RECFG = 5'b0_1000,
    ST_DONE  = 5'b1_0000
  } seq_state_t;

  typedef enum logic [1:0] {
    RC_ANALOG  = 2'h0,
    RC_CHANNEL = 2'h1,
    RC_PLL     = 2'h2,
    RC_NONE    = 2'h3
  } recfg_kind_t;

  typedef struct packed {
    logic        valid;
    recfg_kind_t kind;
    logic [1:0]  channel;
  } recfg_req_t;
endpackage

// [ocal_counter.sv]
// Down counter that times one calibration or reconfiguration pass
`timescale 1ns/10ps
`default_nettype none
`include "ocal_defines.svh"
module ocal_counter
(
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   load_i,
  output logic                        zero_o
);
  logic [`OCAL_CNT_W-1:0] cnt_r;
  logic [`OCAL_CNT_W-1:0] cnt_nxt;
  logic                   zero_r;
  logic                   zero_nxt;

  // Next count; load starts a full pass
  always_comb
  begin
    cnt_nxt  = cnt_r;
    zero_nxt = zero_r;
    if (load_i)
    begin
      cnt_nxt  = `OCAL_SIM_CYCLES - 5'h1;
      zero_nxt = 1'b0;
    end
    else if (cnt_r != 5'h0)
    begin
      cnt_nxt  = cnt_r - 5'h1;
      zero_nxt = (cnt_r == 5'h1);
    end
  end

  // Count registers
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      cnt_r  <= 5'h0;
      zero_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cnt_r  <= cnt_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign zero_o = zero_r;
endmodule
`default_nettype wire

// [offset_cancel_seq.sv]
// Offset-cancel sequencer with per-channel reconfiguration control
`timescale 1ns/10ps
`default_nettype none
`include "ocal_defines.svh"
module offset_cancel_seq
(
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          clk_en_i,
  input  wire ocal_pkg::recfg_req_t          req_i,
  input  wire logic                          user_pwrdn_i,
  input  wire logic [`OCAL_NUM_CH-1:0]       user_ch_rst_i,
  output logic                               busy_o,
  output logic                               cal_done_o,
  output logic                               pwrdn_err_o,
  output logic                               block_pwrdn_o,
  output logic [`OCAL_NUM_CH-1:0]            ch_rst_o,
  output ocal_pkg::recfg_kind_t              recfg_kind_o
);
  ocal_pkg::seq_state_t  st_r;
  ocal_pkg::seq_state_t  st_nxt;
  ocal_pkg::recfg_kind_t kind_r;
  ocal_pkg::recfg_kind_t kind_nxt;
  logic [`OCAL_CH_W-1:0] ch_r;
  logic [`OCAL_CH_W-1:0] ch_nxt;
  logic                  busy_r;
  logic                  busy_nxt;
  logic                  done_r;
  logic                  done_nxt;
  logic                  err_r;
  logic                  err_nxt;
  logic                  pwrdn_r;
  logic [`OCAL_NUM_CH-1:0] rst_r;
  logic [`OCAL_NUM_CH-1:0] rst_nxt;
  logic                  load;
  logic                  cnt_zero;

  // ---------------------------------------------------------------
  // Pass timer
  // ---------------------------------------------------------------
  ocal_counter u_timer
  (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .load_i     (load),
    .zero_o     (cnt_zero)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state, busy and reconfiguration target
  always_comb
  begin
    st_nxt   = st_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    kind_nxt = kind_r;
    ch_nxt   = ch_r;
    load     = 1'b0;
    case (st_r)
      ocal_pkg::ST_IDLE0:
      begin
        st_nxt   = ocal_pkg::ST_CAL;
        busy_nxt = 1'b1;
        load     = 1'b1;
      end
      ocal_pkg::ST_CAL:
      begin
        if (cnt_zero)
        begin
          st_nxt   = ocal_pkg::ST_READY;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      ocal_pkg::ST_READY:
      begin
        // Requests taken only while idle
        if (req_i.valid && req_i.kind != ocal_pkg::RC_NONE)
        begin
          st_nxt   = ocal_pkg::ST_RECFG;
          busy_nxt = 1'b1;
          kind_nxt = req_i.kind;
          ch_nxt   = req_i.channel;
          load     = 1'b1;
        end
      end
      ocal_pkg::ST_RECFG:
      begin
        if (cnt_zero)
        begin
          st_nxt   = ocal_pkg::ST_READY;
          busy_nxt = 1'b0;
          kind_nxt = ocal_pkg::RC_NONE;
        end
      end
      default:
      begin
        st_nxt   = ocal_pkg::ST_IDLE0;
        busy_nxt = `OCAL_BUSY_RST;
      end
    endcase
  end

  // Power-down misuse during calibration is sticky
  always_comb
  begin
    err_nxt = err_r;
    if (st_r == ocal_pkg::ST_CAL && user_pwrdn_i)
      err_nxt = 1'b1;
  end

  // Per-channel resets; the channel under reconfig is held in reset
  genvar g;
  generate
    for (g = 0; g < `OCAL_NUM_CH; g = g + 1)
    begin : g_rst
      always_comb
      begin
        rst_nxt[g] = user_ch_rst_i[g] ||
                     (st_nxt == ocal_pkg::ST_RECFG &&
                      ch_nxt == `OCAL_CH_W'(g));
      end
    end
  endgenerate

  // State registers
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st_r    <= ocal_pkg::ST_IDLE0;
      busy_r  <= `OCAL_BUSY_RST;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      kind_r  <= ocal_pkg::RC_NONE;
      ch_r    <= 2'h0;
      pwrdn_r <= 1'b0;
      rst_r   <= 4'h0;
    end
    else if (clk_en_i)
    begin
      st_r    <= st_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      kind_r  <= kind_nxt;
      ch_r    <= ch_nxt;
      pwrdn_r <= user_pwrdn_i;
      rst_r   <= rst_nxt;
    end
  end

  assign busy_o        = busy_r;
  assign cal_done_o    = done_r;
  assign pwrdn_err_o   = err_r;
  assign block_pwrdn_o = pwrdn_r;
  assign ch_rst_o      = rst_r;
  assign recfg_kind_o  = kind_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Enabled edges seen with busy high, for the pass-length check
  logic [`OCAL_CNT_W-1:0] span_r;
  logic [`OCAL_CNT_W-1:0] span_nxt;

  // Next span count; restarts whenever busy is low
  always_comb
  begin
    span_nxt = 5'h0;
    if (busy_r)
      span_nxt = span_r + 5'h1;
  end

  // Span register, frozen with the clock enable like the timer
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      span_r <= 5'h0;
    else if (clk_en_i)
      span_r <= span_nxt;
  end

  property p_first_low;
    @(posedge core_clk_i) disable iff (reset_i)
    ($fell(reset_i) && clk_en_i) |-> !busy_o;
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("busy high in first cycle");

  property p_rise_second;
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r == ocal_pkg::ST_IDLE0 && clk_en_i) |=> busy_o;
  endproperty
  a_rise_second: assert property (p_rise_second)
    else $error("busy not raised in second cycle");

  property p_fall_done;
    @(posedge core_clk_i) disable iff (reset_i)
    ($fell(busy_o) && !cal_done_o) |-> 1'b0;
  endproperty
  a_fall_done: assert property (p_fall_done)
    else $error("busy fell before calibration done");

  property p_sixteen;
    @(posedge core_clk_i) disable iff (reset_i)
    ($fell(busy_o) && !$past(reset_i)) |-> span_r == `OCAL_SIM_CYCLES;
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("calibration not sixteen cycles");

  property p_recfg_reset;
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r == ocal_pkg::ST_RECFG) |-> ch_rst_o[ch_r];
  endproperty
  a_recfg_reset: assert property (p_recfg_reset)
    else $error("reconfigured channel not in reset");

  property p_pwrdn_follow;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i |=> block_pwrdn_o == $past(user_pwrdn_i);
  endproperty
  a_pwrdn_follow: assert property (p_pwrdn_follow)
    else $error("power-down not forwarded");

  property p_err_sticky;
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r == ocal_pkg::ST_CAL && user_pwrdn_i && clk_en_i) |=> pwrdn_err_o;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("power-down during calibration not flagged");

  property p_no_take_busy;
    @(posedge core_clk_i) disable iff (reset_i)
    (busy_o && st_r == ocal_pkg::ST_RECFG && !cnt_zero) |=>
      $stable(ch_r);
  endproperty
  a_no_take_busy: assert property (p_no_take_busy)
    else $error("request taken while busy");
endmodule
`default_nettype wire

// [user_model.sv]
// User-side partner: reconfig requests and block power-down
`timescale 1ns/10ps
`default_nettype none
module user_model
(
  input  wire logic                  core_clk_i,
  input  wire logic                  busy_i,
  input  wire logic                  go_i,
  input  wire ocal_pkg::recfg_kind_t kind_i,
  input  wire logic [1:0]            ch_i,
  input  wire logic                  pwr_i,
  input  wire logic                  bad_i,
  output ocal_pkg::recfg_req_t       req_o,
  output logic                       pwrdn_o
);
  logic g;
  logic p;
  // Quiet outputs at time zero
  initial
  begin
    req_o = '0;
    pwrdn_o = 1'b0;
  end
  // One-cycle request only while idle; power-down held off while busy unless bad_i is set
  always @(posedge core_clk_i)
  begin
    g = go_i;
    p = pwr_i;
    #1;
    if (g && !busy_i)
      req_o <= {1'b1, kind_i, ch_i};
    else
      req_o <= {1'b0, ~req_o.kind, ~req_o.channel};
    pwrdn_o <= p && (!busy_i || bad_i);
  end
endmodule
`default_nettype wire

// [offset_cancel_seq_tb_top.sv]
// Self-checking bench for the offset-cancel sequencer
`timescale 1ns/10ps
`default_nettype none
module offset_cancel_seq_tb_top;
  logic                  core_clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  clk_en_i = 1'b1;
  logic                  go = 1'b0;
  logic                  pwr = 1'b0;
  logic                  bad = 1'b0;
  logic [1:0]            ch = 2'h0;
  logic [3:0]            urst = 4'h0;
  ocal_pkg::recfg_kind_t kind = ocal_pkg::RC_ANALOG;
  ocal_pkg::recfg_req_t  req;
  ocal_pkg::recfg_kind_t rkind;
  logic                  pwrdn;
  logic                  busy;
  logic                  done;
  logic                  perr;
  logic                  bpd;
  logic [3:0]            crst;
  int                    errors = 0;
  int                    num_checks = 0;
  int                    seed = 32'hf0e2_714c;
  int                    n;
  int                    k;

  // 125 MHz clock
  always #4 core_clk_i = ~core_clk_i;

  user_model i_user_model
  (
    .core_clk_i (core_clk_i),
    .busy_i     (busy),
    .go_i       (go),
    .kind_i     (kind),
    .ch_i       (ch),
    .pwr_i      (pwr),
    .bad_i      (bad),
    .req_o      (req),
    .pwrdn_o    (pwrdn)
  );

  offset_cancel_seq i_offset_cancel_seq
  (
    .core_clk_i    (core_clk_i),
    .reset_i       (reset_i),
    .clk_en_i      (clk_en_i),
    .req_i         (req),
    .user_pwrdn_i  (pwrdn),
    .user_ch_rst_i (urst),
    .busy_o        (busy),
    .cal_done_o    (done),
    .pwrdn_err_o   (perr),
    .block_pwrdn_o (bpd),
    .ch_rst_o      (crst),
    .recfg_kind_o  (rkind)
  );

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask

  // Count enabled edges until busy falls, bounded
  task automatic wait_idle(input logic rnd);
    logic en;
    n = 0;
    repeat (300)
    begin
      if (busy !== 1'b1)
        break;
      if (rnd)
        clk_en_i = 1'($random(seed));
      en = clk_en_i;
      step();
      n += int'(en);
    end
    clk_en_i = 1'b1;
    if (busy !== 1'b0)
    begin
      errors++;
      complete_run();
    end
  endtask

  // Reset, then the calibration pass
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (6) step();
    check(busy, 8'h0);
    check(rkind, 8'h3);
    check(crst, 8'h0);
    reset_i = 1'b0;
    check(busy, 8'h0);
    step();
    check(busy, 8'h1);
    check(done, 8'h0);
    wait_idle(1'b0);
    check(8'(n), 8'h10);
    check(done, 8'h1);
  endtask

  // One reconfiguration request and, unless its kind is RC_NONE, its pass
  task automatic recfg(input logic [1:0] kd, input logic [1:0] c,
                       input logic rnd);
    logic [3:0] u;
    u = 4'($random(seed));
    urst = u;
    kind = ocal_pkg::recfg_kind_t'(kd);
    ch = c;
    go = 1'b1;
    step();
    go = 1'b0;
    step();
    check(busy, 8'(kd != 2'h3));
    if (kd != 2'h3)
    begin
      check(rkind, kd);
      check(crst, u | (4'h1 << c));
      wait_idle(rnd);
      check(8'(n), 8'h10);
      check(rkind, 8'h3);
      check(crst, u);
    end
  endtask

  // Main sequence
  initial
  begin
    do_reset();
    check(perr, 8'h0);
    pwr = 1'b1;
    repeat (2) step();
    check(bpd, 8'h1);
    pwr = 1'b0;
    repeat (2) step();
    check(bpd, 8'h0);
    for (k = 0; k < 4; k++)
      recfg(2'(k), 2'(3 - k), 1'b0);
    repeat (6)
      recfg(2'($random(seed)), 2'($random(seed)), 1'b1);
    bad = 1'b1;
    pwr = 1'b1;
    do_reset();
    check(perr, 8'h1);
    complete_run();
  end
endmodule
`default_nettype wire
